//--- core/irc_defines.svh
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH

// Bus and array sizes.
`define IRC_AW          8
`define IRC_DW          32
`define IRC_N_WIRED     16
`define IRC_N_LMI       8
`define IRC_N_ALL       24
`define IRC_N_SW        4
`define IRC_N_PERIPH    12
`define IRC_PW          4

// Register offsets on the memory-mapped port (byte addresses).
`define IRC_OFF_CTRL    8'h00
`define IRC_OFF_SRE     8'h04
`define IRC_OFF_GRP     8'h08
`define IRC_OFF_GRPMOD  8'h0C
`define IRC_OFF_PRIO0   8'h10
`define IRC_OFF_PRIO1   8'h14
`define IRC_OFF_LPRIO   8'h18
`define IRC_OFF_SETPEND 8'h1C
`define IRC_OFF_CLRPEND 8'h20
`define IRC_OFF_PEND    8'h24
`define IRC_OFF_SWISSUE 8'h28
`define IRC_OFF_STATUS  8'h2C
`define IRC_OFF_PMR     8'h30
`define IRC_OFF_ACK     8'h34
`define IRC_OFF_EOI     8'h38

// Offsets on the system-register port.
`define IRC_SR_PMR      2'h0
`define IRC_SR_ACK      2'h1
`define IRC_SR_EOI      2'h2

// Field positions.
`define IRC_CTRL_NONSECURE_AFFINITY_ROUTE_ENABLE 0
`define IRC_CTRL_ARE_S  1
`define IRC_ST_LEGACY   0
`define IRC_ST_SYSREG   1
`define IRC_ST_VINJ     2
`define IRC_ST_FIQ      3
`define IRC_ST_IRQ      4
`define IRC_ID_LSB      0
`define IRC_ID_MSB      4
`define IRC_SRC_LSB     8
`define IRC_SRC_MSB     10
`define IRC_PMR_MSB     3

// Constants and reset values.
`define IRC_EL_IMPL     3'h7
`define IRC_LMI_BASE    5'h10
`define IRC_SPURIOUS    5'h1F
`define IRC_PMR_RST     4'h0
`define IRC_LMI_UNITS   1

`endif

//--- core/irc_pkg.sv
package irc_pkg;

    // Memory-mapped register request.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } irc_bus_req_t;

    // System-register request towards the CPU interface.
    typedef struct packed {
        logic [1:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } irc_sr_req_t;

    // Message from the translation unit.
    typedef struct packed {
        logic       valid;
        logic [2:0] id;
    } irc_lmi_msg_t;

    // Interrupt group of an interrupt.
    typedef enum logic [1:0] {
        IRC_GRP0,
        IRC_GRP1_S,
        IRC_GRP1_NS
    } irc_group_t;

    // Complete state of the controller.
    typedef struct packed {
        logic                nonsecure_affinity_route_enable;
        logic                are_s;
        logic [2:0]          system_register_access_enable;
        logic [15:0]         grp;
        logic [15:0]         grpmod;
        logic [15:0][3:0]    prio;
        logic [3:0]          lprio;
        logic [23:0]         pend;
        logic [15:0]         act;
        logic [3:0][2:0]     src;
        logic [3:0]          pmr;
        logic [11:0]         prev_in;
        logic [31:0]         rdata;
        logic [31:0]         srdata;
        logic                fiq;
        logic                irq;
    } irc_state_t;

endpackage

//--- core/irc_prio_pick.sv
`include "irc_defines.svh"

// Picks the pending candidate of highest priority (lowest value, lowest id on ties).
module irc_prio_pick
    import irc_pkg::*;
(
    input  wire logic [23:0]       cand,
    input  wire logic [23:0][3:0]  prio,
    output logic                   found,
    output logic [4:0]             best_id,
    output logic [3:0]             best_prio
);

    // Scan downwards so that an equal priority keeps the lowest id.
    always_comb begin
        found     = 1'b0;
        best_id   = 5'h00;
        best_prio = 4'hF;
        for (int i = `IRC_N_ALL - 1; i >= 0; i--) begin
            if (cand[i] && (!found || prio[i] <= best_prio)) begin
                found     = 1'b1;
                best_id   = 5'(i);
                best_prio = prio[i];
            end
        end
    end

endmodule // irc_prio_pick

//--- core/irc_top.sv
// Contract
// - Software places every wired interrupt in group 0, secure group 1 or non-secure group 1.
// - A pending group 0 interrupt is signalled on the fast request line.
// - Group 1 interrupts reach the normal request line of the element in their own state.
// - One priority scheme and one mask compare and gate both groups together.
// - Affinity routing of each security state is on only while its enable bit is 1.
// - The system-register path works only when the access enable is 1 at every level.
// - Only the interrupt handling and priority mask registers use the system-register path.
// - In legacy operation every controller register is reachable memory-mapped.
// - Translated messages only ever become locality message interrupts.
// - Outside legacy operation a software-issued interrupt carries no source identity.
// - Dedicated registers set and clear pending shared message interrupts.
// - Direct virtual injection is offered only with a locality translation unit present.
// - Locality interrupts are edge-like, never active, and go inactive on acknowledge.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`include "irc_defines.svh"

module irc_top
    import irc_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire irc_bus_req_t  bus,
    output logic [31:0]        bus_rdata,
    input  wire irc_sr_req_t   sr,
    output logic [31:0]        sr_rdata,
    input  wire irc_lmi_msg_t  lmi,
    input  wire logic [11:0]   periph_in,
    input  wire logic          pe_secure,
    output logic               fiq_o,
    output logic               irq_o,
    output logic               aff_route_ns_o,
    output logic               aff_route_s_o,
    output logic               sysreg_on_o,
    output logic               virt_inject_ok_o
);

    irc_state_t        st_r;
    irc_state_t        st_nxt;
    logic              legacy;
    logic              sysreg_en;
    logic              mm_cpu_ok;
    logic              vinj_ok;
    logic              found;
    logic [4:0]        best_id;
    logic [3:0]        best_prio;
    logic [23:0]       cand;
    logic [23:0][3:0]  prio_all;
    irc_group_t        best_grp;
    logic              hit;
    logic              fiq_nxt;
    logic              ack_mm;
    logic              ack_sr;
    logic              ack_take;
    logic [31:0]       ack_word;
    logic [4:0]        lmi_idx;
    logic [11:0]       rise;

    // Operating mode: legacy when neither state routes by affinity.
    assign legacy    = !st_r.nonsecure_affinity_route_enable && !st_r.are_s;
    assign sysreg_en = &(st_r.system_register_access_enable | ~`IRC_EL_IMPL);
    assign mm_cpu_ok = legacy || !sysreg_en;
    assign vinj_ok   = (`IRC_LMI_UNITS != 0);

    // Candidates: wired interrupts while not active, locality ones whenever pending.
    assign cand     = {st_r.pend[23:16], st_r.pend[15:0] & ~st_r.act};
    assign prio_all = {{`IRC_N_LMI{st_r.lprio}}, st_r.prio};

    irc_prio_pick u_pick (
        .cand      (cand),
        .prio      (prio_all),
        .found     (found),
        .best_id   (best_id),
        .best_prio (best_prio)
    );

    // Group of the winner; locality interrupts are always non-secure group 1.
    always_comb begin
        if (best_id >= `IRC_LMI_BASE) begin
            best_grp = IRC_GRP1_NS;
        end else if (st_r.grp[best_id[3:0]]) begin
            best_grp = IRC_GRP1_NS;
        end else if (st_r.grpmod[best_id[3:0]]) begin
            best_grp = IRC_GRP1_S;
        end else begin
            best_grp = IRC_GRP0;
        end
    end

    // One mask against one priority for every group.
    assign hit     = found && (best_prio < st_r.pmr);
    assign fiq_nxt = hit && ((best_grp == IRC_GRP0) ||
                     (best_grp == IRC_GRP1_S && !pe_secure) ||
                     (best_grp == IRC_GRP1_NS && pe_secure));

    // Acknowledge through whichever path is open for the CPU interface.
    assign ack_mm   = bus.rd && (bus.addr == `IRC_OFF_ACK) && mm_cpu_ok;
    assign ack_sr   = sr.rd && (sr.addr == `IRC_SR_ACK) && sysreg_en;
    assign ack_take = (ack_mm || ack_sr) && hit;

    // Acknowledge word: id in the low bits, stored source above it in legacy only.
    always_comb begin
        ack_word = 32'h0000_0000;
        ack_word[`IRC_ID_MSB:`IRC_ID_LSB] = hit ? best_id : `IRC_SPURIOUS;
        if (hit && legacy && best_id < 5'(`IRC_N_SW)) begin
            ack_word[`IRC_SRC_MSB:`IRC_SRC_LSB] = st_r.src[best_id[1:0]];
        end
    end

    assign lmi_idx = `IRC_LMI_BASE | {2'h0, lmi.id};
    assign rise    = periph_in & ~st_r.prev_in;

    // Next state: clears first, then sets, so a set in the same cycle wins.
    always_comb begin
        st_nxt         = st_r;
        st_nxt.rdata   = 32'h0000_0000;
        st_nxt.srdata  = 32'h0000_0000;
        st_nxt.prev_in = periph_in;
        st_nxt.fiq     = fiq_nxt;
        st_nxt.irq     = hit && !fiq_nxt;

        // Acknowledge: the winner leaves pending; wired ones turn active further down.
        if (ack_take) begin
            st_nxt.pend[best_id] = 1'b0;
        end

        // Memory-mapped writes.
        if (bus.wr) begin
            if (bus.addr == `IRC_OFF_CTRL) begin
                st_nxt.nonsecure_affinity_route_enable = bus.wdata[`IRC_CTRL_NONSECURE_AFFINITY_ROUTE_ENABLE];
                st_nxt.are_s  = bus.wdata[`IRC_CTRL_ARE_S];
            end else if (bus.addr == `IRC_OFF_SRE) begin
                st_nxt.system_register_access_enable = bus.wdata[2:0];
            end else if (bus.addr == `IRC_OFF_GRP) begin
                st_nxt.grp = bus.wdata[15:0];
            end else if (bus.addr == `IRC_OFF_GRPMOD) begin
                st_nxt.grpmod = bus.wdata[15:0];
            end else if (bus.addr == `IRC_OFF_PRIO0) begin
                st_nxt.prio[7:0] = bus.wdata;
            end else if (bus.addr == `IRC_OFF_PRIO1) begin
                st_nxt.prio[15:8] = bus.wdata;
            end else if (bus.addr == `IRC_OFF_LPRIO) begin
                st_nxt.lprio = bus.wdata[3:0];
            end else if (bus.addr == `IRC_OFF_CLRPEND) begin
                st_nxt.pend[15:4] = st_nxt.pend[15:4] & ~bus.wdata[15:4];
            end else if (bus.addr == `IRC_OFF_PMR && mm_cpu_ok) begin
                st_nxt.pmr = bus.wdata[`IRC_PMR_MSB:0];
            end else if (bus.addr == `IRC_OFF_EOI && mm_cpu_ok) begin
                if (bus.wdata[`IRC_ID_MSB:`IRC_ID_LSB] < `IRC_LMI_BASE) begin
                    st_nxt.act[bus.wdata[3:0]] = 1'b0;
                end
            end
        end

        // System-register writes, only while that path is enabled.
        if (sr.wr && sysreg_en) begin
            if (sr.addr == `IRC_SR_PMR) begin
                st_nxt.pmr = sr.wdata[`IRC_PMR_MSB:0];
            end else if (sr.addr == `IRC_SR_EOI) begin
                if (sr.wdata[`IRC_ID_MSB:`IRC_ID_LSB] < `IRC_LMI_BASE) begin
                    st_nxt.act[sr.wdata[3:0]] = 1'b0;
                end
            end
        end

        // Set events last, so that they win over a clear in the same cycle.
        if (ack_take && best_id < `IRC_LMI_BASE) begin
            st_nxt.act[best_id[3:0]] = 1'b1;
        end
        st_nxt.pend[15:4] = st_nxt.pend[15:4] | rise;
        if (lmi.valid) begin
            st_nxt.pend[lmi_idx] = 1'b1;
        end
        if (bus.wr && bus.addr == `IRC_OFF_SETPEND) begin
            st_nxt.pend[15:4] = st_nxt.pend[15:4] | bus.wdata[15:4];
        end
        if (bus.wr && bus.addr == `IRC_OFF_SWISSUE) begin
            st_nxt.pend[{3'h0, bus.wdata[1:0]}] = 1'b1;
            st_nxt.src[bus.wdata[1:0]] = legacy ?
                bus.wdata[`IRC_SRC_MSB:`IRC_SRC_LSB] : 3'h0;
        end

        // Memory-mapped reads.
        if (bus.rd) begin
            if (bus.addr == `IRC_OFF_CTRL) begin
                st_nxt.rdata[`IRC_CTRL_NONSECURE_AFFINITY_ROUTE_ENABLE] = st_r.nonsecure_affinity_route_enable;
                st_nxt.rdata[`IRC_CTRL_ARE_S]  = st_r.are_s;
            end else if (bus.addr == `IRC_OFF_SRE) begin
                st_nxt.rdata[2:0] = st_r.system_register_access_enable;
            end else if (bus.addr == `IRC_OFF_GRP) begin
                st_nxt.rdata[15:0] = st_r.grp;
            end else if (bus.addr == `IRC_OFF_GRPMOD) begin
                st_nxt.rdata[15:0] = st_r.grpmod;
            end else if (bus.addr == `IRC_OFF_PRIO0) begin
                st_nxt.rdata = st_r.prio[7:0];
            end else if (bus.addr == `IRC_OFF_PRIO1) begin
                st_nxt.rdata = st_r.prio[15:8];
            end else if (bus.addr == `IRC_OFF_LPRIO) begin
                st_nxt.rdata[3:0] = st_r.lprio;
            end else if (bus.addr == `IRC_OFF_PEND) begin
                st_nxt.rdata[23:0] = st_r.pend;
            end else if (bus.addr == `IRC_OFF_STATUS) begin
                st_nxt.rdata[`IRC_ST_LEGACY] = legacy;
                st_nxt.rdata[`IRC_ST_SYSREG] = sysreg_en;
                st_nxt.rdata[`IRC_ST_VINJ]   = vinj_ok;
                st_nxt.rdata[`IRC_ST_FIQ]    = st_r.fiq;
                st_nxt.rdata[`IRC_ST_IRQ]    = st_r.irq;
            end else if (bus.addr == `IRC_OFF_PMR && mm_cpu_ok) begin
                st_nxt.rdata[`IRC_PMR_MSB:0] = st_r.pmr;
            end else if (bus.addr == `IRC_OFF_ACK && mm_cpu_ok) begin
                st_nxt.rdata = ack_word;
            end
        end

        // System-register reads.
        if (sr.rd && sysreg_en) begin
            if (sr.addr == `IRC_SR_PMR) begin
                st_nxt.srdata[`IRC_PMR_MSB:0] = st_r.pmr;
            end else if (sr.addr == `IRC_SR_ACK) begin
                st_nxt.srdata = ack_word;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state.
    assign bus_rdata        = st_r.rdata;
    assign sr_rdata         = st_r.srdata;
    assign fiq_o            = st_r.fiq;
    assign irq_o            = st_r.irq;
    assign aff_route_ns_o   = st_r.nonsecure_affinity_route_enable;
    assign aff_route_s_o    = st_r.are_s;
    assign sysreg_on_o      = sysreg_en;
    assign virt_inject_ok_o = vinj_ok;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_group_zero_fast: assert property (hit && best_grp == IRC_GRP0 |=> fiq_o && !irq_o)
        else $error("group 0 winner not on fast line");
    a_group_one_own: assert property (
        hit && best_grp == IRC_GRP1_NS && !pe_secure |=> irq_o && !fiq_o)
        else $error("own-state group 1 winner not on normal line");
    a_mask_blocks_all: assert property (!hit |=> !fiq_o && !irq_o)
        else $error("masked interrupt was signalled");
    a_group_write_seen: assert property (
        bus.wr && bus.addr == `IRC_OFF_GRP |=> st_r.grp == $past(bus.wdata[15:0]))
        else $error("group assignment not stored");
    a_route_enable_ns: assert property (
        bus.wr && bus.addr == `IRC_OFF_CTRL
        |=> aff_route_ns_o == $past(bus.wdata[`IRC_CTRL_NONSECURE_AFFINITY_ROUTE_ENABLE]))
        else $error("affinity enable does not follow its bit");
    a_sysreg_gated: assert property (sr.rd && !sysreg_en |=> sr_rdata == 32'h0000_0000)
        else $error("system-register read answered while disabled");
    a_mm_cpu_closed: assert property (
        bus.rd && bus.addr == `IRC_OFF_PMR && !mm_cpu_ok |=> bus_rdata == 32'h0000_0000)
        else $error("mask register visible in memory map");
    a_legacy_mm_open: assert property (
        bus.rd && bus.addr == `IRC_OFF_PMR && legacy
        |=> bus_rdata[`IRC_PMR_MSB:0] == $past(st_r.pmr))
        else $error("legacy memory-mapped mask read failed");
    a_msg_locality: assert property (lmi.valid |=> st_r.pend[$past(lmi_idx)])
        else $error("message did not set a locality interrupt");
    a_ack_no_source: assert property (
        bus.rd && bus.addr == `IRC_OFF_ACK && !legacy
        |=> bus_rdata[`IRC_SRC_MSB:`IRC_SRC_LSB] == 3'h0)
        else $error("source identity leaked outside legacy");
    a_set_pending: assert property (
        bus.wr && bus.addr == `IRC_OFF_SETPEND && !ack_sr
        |=> (st_r.pend[15:4] & $past(bus.wdata[15:4])) == $past(bus.wdata[15:4]))
        else $error("set-pending write lost");
    a_vinj_status: assert property (
        bus.rd && bus.addr == `IRC_OFF_STATUS |=> bus_rdata[`IRC_ST_VINJ] == vinj_ok)
        else $error("virtual injection flag wrong");
    a_lmi_ack_idle: assert property (
        ack_take && best_id >= `IRC_LMI_BASE && !lmi.valid
        |=> !st_r.pend[$past(best_id)])
        else $error("locality interrupt stayed pending after acknowledge");

    c_fast_taken: cover property (fiq_o ##1 ack_take);
    c_normal_taken: cover property (irq_o ##1 ack_sr);
    c_lmi_ack: cover property (lmi.valid ##[1:20] ack_take && best_id >= `IRC_LMI_BASE);
    c_legacy_sw: cover property (legacy && bus.wr && bus.addr == `IRC_OFF_SWISSUE);

endmodule // irc_top

//--- bench/irc_pe_model.sv
`include "irc_defines.svh"

// Processing element at the far side: takes one request at a time over the system registers.
module irc_pe_model
    import irc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        fiq,
    input  wire logic        irq,
    input  wire logic        sysreg_on,
    input  wire logic [31:0] sr_rdata,
    input  wire logic        ack_en,
    input  wire logic [3:0]  slow,
    output irc_sr_req_t      sr,
    output logic [31:0]      ack_word,
    output logic [7:0]       acks
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] wait_r;
    logic [2:0] step_r;

    // Waits a programmable time, acknowledges, then ends the interrupt that it took.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sr       <= '0;
            ack_word <= 32'h0000_0000;
            acks     <= 8'h00;
            wait_r   <= 4'h0;
            step_r   <= 3'h0;
        end else begin
            sr.rd    <= 1'b0;
            sr.wr    <= 1'b0;
            sr.wdata <= ~sr.wdata;  // Idle data lines never hold a stale value.
            case (step_r)
                3'h0: begin
                    if (ack_en && sysreg_on && (fiq || irq)) begin
                        wait_r <= slow;
                        step_r <= 3'h1;
                    end
                end
                3'h1: begin
                    if (wait_r == 4'h0) begin
                        sr.addr <= `IRC_SR_ACK;
                        sr.rd   <= 1'b1;
                        step_r  <= 3'h2;
                    end else begin
                        wait_r <= wait_r - 4'h1;
                    end
                end
                3'h2: step_r <= 3'h3;
                3'h3: begin
                    ack_word <= sr_rdata;
                    acks     <= acks + 8'h01;
                    sr.addr  <= `IRC_SR_EOI;
                    sr.wdata <= {27'h0, sr_rdata[4:0]};
                    sr.wr    <= 1'b1;
                    wait_r   <= 4'h2;
                    step_r   <= 3'h4;
                end
                default: begin
                    if (wait_r == 4'h0) begin
                        step_r <= 3'h0;
                    end else begin
                        wait_r <= wait_r - 4'h1;
                    end
                end
            endcase
        end
    end
endmodule // irc_pe_model

//--- bench/interrupt_group_routing_control_test.sv
`include "irc_defines.svh"

module interrupt_group_routing_control_test
    import irc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic         clk_sys, nrst, pe_secure, fiq_o, irq_o, ack_en;
    logic         aff_route_ns_o, aff_route_s_o, sysreg_on_o, virt_inject_ok_o;
    irc_bus_req_t bus;
    irc_sr_req_t  sr;
    irc_lmi_msg_t lmi;
    logic [31:0]  bus_rdata, sr_rdata, ack_word;
    logic [11:0]  periph_in;
    logic [7:0]   acks;
    logic [3:0]   slow;
    int           err_count, comparisons, cycles;

    irc_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .bus(bus), .bus_rdata(bus_rdata), .sr(sr),
        .sr_rdata(sr_rdata), .lmi(lmi), .periph_in(periph_in), .pe_secure(pe_secure),
        .fiq_o(fiq_o), .irq_o(irq_o), .aff_route_ns_o(aff_route_ns_o),
        .aff_route_s_o(aff_route_s_o), .sysreg_on_o(sysreg_on_o),
        .virt_inject_ok_o(virt_inject_ok_o));

    irc_pe_model i_pe (.clk_sys(clk_sys), .nrst(nrst), .fiq(fiq_o), .irq(irq_o),
        .sysreg_on(sysreg_on_o), .sr_rdata(sr_rdata), .ack_en(ack_en), .slow(slow),
        .sr(sr), .ack_word(ack_word), .acks(acks));

    // Clock generation, 5 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        chk(what, exp, bus_rdata);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic req_chk(input logic [1:0] exp);
        chk("fiq and irq", {30'h0, exp}, {30'h0, fiq_o, irq_o});
    endtask

    // Lets the element take one interrupt and compares what the acknowledge returned.
    task automatic pe_ack(input logic [31:0] exp);
        logic [7:0] n0;
        int         k;
        n0 = acks;
        k = 0;
        ack_en = 1'b1;
        while (acks === n0 && k < 60) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        ack_en = 1'b0;
        chk("acknowledge word", exp, ack_word);
        chk("acknowledge count", {24'h0, n0 + 8'h01}, {24'h0, acks});
        settle();
    endtask

    task automatic t_reset;
        chk("virtual inject", 32'h1, {31'h0, virt_inject_ok_o});
        req_chk(2'b00);
        rd_chk("status", `IRC_OFF_STATUS, 32'h0000_0005);
    endtask

    task automatic t_affinity;
        for (int i = 0; i < 4; i++) begin
            wr(`IRC_OFF_CTRL, 32'(i));
            settle();
            chk("route ns", {31'h0, i[0]}, {31'h0, aff_route_ns_o});
            chk("route s", {31'h0, i[1]}, {31'h0, aff_route_s_o});
            rd_chk("status", `IRC_OFF_STATUS, (i == 0) ? 32'h5 : 32'h4);
        end
        wr(`IRC_OFF_CTRL, 32'h0);
    endtask

    // Every group against both security states of the element.
    task automatic t_groups;
        logic f;
        wr(`IRC_OFF_PMR, 32'hF);
        rd_chk("mask", `IRC_OFF_PMR, 32'hF);
        wr(`IRC_OFF_PRIO0, 32'h0010_0000);
        for (int g = 0; g < 3; g++) begin
            for (int s = 0; s < 2; s++) begin
                f = (g == 0) || (g == 1 && s == 0) || (g == 2 && s == 1);
                wr(`IRC_OFF_GRP, (g == 2) ? 32'h20 : 32'h0);
                wr(`IRC_OFF_GRPMOD, (g == 1) ? 32'h20 : 32'h0);
                pe_secure <= s[0];
                wr(`IRC_OFF_SETPEND, 32'h0001_0021);
                settle();
                rd_chk("pending set", `IRC_OFF_PEND, 32'h20);
                req_chk({f, ~f});
                wr(`IRC_OFF_CLRPEND, 32'h20);
                settle();
                rd_chk("pending clear", `IRC_OFF_PEND, 32'h0);
                req_chk(2'b00);
            end
        end
        wr(`IRC_OFF_SETPEND, 32'h20);
        settle();
        rd_chk("bus acknowledge", `IRC_OFF_ACK, 32'h5);
        wr(`IRC_OFF_EOI, 32'h5);
        settle();
        req_chk(2'b00);
    endtask

    // One priority order and one mask across both groups.
    task automatic t_mask;
        logic [31:0] pw [4] = '{32'h0010_0000, 32'h0010_0000, 32'h0210_0000, 32'h0210_0000};
        logic [31:0] pm [4] = '{32'h0, 32'h1, 32'h2, 32'h1};
        logic [1:0]  ex [4] = '{2'b00, 2'b01, 2'b10, 2'b00};
        pe_secure <= 1'b0;
        wr(`IRC_OFF_GRP, 32'h40);
        wr(`IRC_OFF_GRPMOD, 32'h0);
        wr(`IRC_OFF_SETPEND, 32'h60);
        for (int i = 0; i < 4; i++) begin
            wr(`IRC_OFF_PRIO0, pw[i]);
            wr(`IRC_OFF_PMR, pm[i]);
            settle();
            req_chk(ex[i]);
        end
        wr(`IRC_OFF_CLRPEND, 32'h60);
        wr(`IRC_OFF_PMR, 32'hF);
    endtask

    task automatic t_sysreg;
        wr(`IRC_OFF_CTRL, 32'h3);
        wr(`IRC_OFF_SRE, 32'h3);
        settle();
        chk("sysreg partial", 32'h0, {31'h0, sysreg_on_o});
        wr(`IRC_OFF_SRE, 32'h7);
        settle();
        chk("sysreg full", 32'h1, {31'h0, sysreg_on_o});
        rd_chk("status", `IRC_OFF_STATUS, 32'h6);
        rd_chk("mask closed", `IRC_OFF_PMR, 32'h0);
        wr(`IRC_OFF_PMR, 32'h0);
        wr(`IRC_OFF_PRIO0, 32'h0002_0000);
        wr(`IRC_OFF_GRP, 32'h0);
        periph_in <= 12'h001;
        settle();
        req_chk(2'b10);
        slow = 4'h5;
        pe_ack(32'h4);
        slow = 4'h0;
        req_chk(2'b00);
        periph_in <= 12'h000;
    endtask

    task automatic t_lmi;
        wr(`IRC_OFF_LPRIO, 32'h1);
        for (int n = 0; n < 2; n++) begin
            @(posedge clk_sys);
            lmi <= '{valid: 1'b1, id: 3'h3};
            @(posedge clk_sys);
            lmi <= '0;
            settle();
            rd_chk("message pending", `IRC_OFF_PEND, 32'h0008_0000);
            req_chk(2'b01);
            pe_ack(32'h13);
            req_chk(2'b00);
        end
    endtask

    task automatic t_swi;
        wr(`IRC_OFF_PRIO0, 32'h0000_0100);
        for (int leg = 0; leg < 2; leg++) begin
            wr(`IRC_OFF_CTRL, (leg == 0) ? 32'h3 : 32'h0);
            wr(`IRC_OFF_SWISSUE, 32'h0000_0502);
            settle();
            req_chk(2'b10);
            if (leg == 0) begin
                rd_chk("acknowledge closed", `IRC_OFF_ACK, 32'h0);
            end
            pe_ack((leg == 0) ? 32'h2 : 32'h502);
        end
    endtask

    // Main sequence: reset, then one scenario after another.
    initial begin
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        nrst = 1'b0;
        bus = '0;
        lmi = '0;
        periph_in = 12'h000;
        pe_secure = 1'b0;
        ack_en = 1'b0;
        slow = 4'h0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_affinity();
        t_groups();
        t_mask();
        t_sysreg();
        t_lmi();
        t_swi();
        wrap_up();
    end
endmodule // interrupt_group_routing_control_test
